// *** verilog/level_ctrl_pkg.sv ***
// Shared constants and types for the level control limits block
package level_ctrl_pkg;

   // ==========================================
   // Control port registers
   localparam logic [6:0] ADDR_CFG_ONE   = 7'h10;
   localparam logic [6:0] ADDR_CFG_TWO   = 7'h11;
   localparam logic [6:0] ADDR_GATE      = 7'h13;
   localparam logic [6:0] ADDR_ATTEN     = 7'h14;
   localparam logic [6:0] ADDR_MUX       = 7'h15;
   localparam logic [6:0] ADDR_SOFT_RST  = 7'h17;

   localparam logic [8:0] RST_CFG_ONE    = 9'h07B;
   localparam logic [8:0] RST_CFG_TWO    = 9'h000;
   localparam logic [8:0] RST_GATE       = 9'h000;
   localparam logic [8:0] RST_ATTEN      = 9'h0A6;
   localparam logic [8:0] RST_MUX        = 9'h001;

   // ==========================================
   // Field positions
   localparam int FUNC_SEL_LSB   = 7;
   localparam int CEIL_LSB       = 4;
   localparam int ENABLE_BIT     = 8;
   localparam int HOLD_LSB       = 0;
   localparam int GATE_EN_BIT    = 0;
   localparam int GATE_TH_LSB    = 2;
   localparam int FLOOR_LSB      = 0;
   localparam int SELECT_LSB     = 0;
   localparam int POWERDOWN_BIT  = 6;

   // ==========================================
   // Gain figures in half-dB steps, plus floor/attenuation codes and the overload sample level
   typedef logic signed [7:0] gain_type;
   localparam gain_type PGA_MAX_HDB      = 8'sd48;
   localparam gain_type PGA_MIN_HDB      = -8'sd42;
   localparam gain_type ALC_FLOOR_HI_HDB = -8'sd2;
   localparam gain_type ALC_FLOOR_B_HDB  = -8'sd10;
   localparam logic [3:0] ALC_FLOOR_KNEE = 4'hB;
   localparam logic [3:0] ATTEN_MIN_CODE = 4'h3;
   localparam logic [3:0] ATTEN_MAX_CODE = 4'hC;
   localparam gain_type GATE_TH_BASE     = -8'sd78;
   localparam logic [7:0] GATE_TH_STEP   = 8'h06;
   localparam logic [23:0] OVERLOAD_LEVEL = 24'h70_0000;

   // ==========================================
   // Hold timing
   localparam int CLK_PERIOD_NS    = 5;
   localparam int HOLD_BASE_NS     = 2670000;
   localparam int HOLD_BASE_CYCLES =
      (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      FUNC_LIMITER    = 2'b00,
      FUNC_ALC_RIGHT  = 2'b01,
      FUNC_ALC_LEFT   = 2'b10,
      FUNC_ALC_STEREO = 2'b11
   } level_func_type;

   typedef struct packed {
      gain_type ceiling;
      gain_type floor;
   } limits_type;

endpackage : level_ctrl_pkg

// *** verilog/gain_step_channel.sv ***
// One channel of gain stepping with hold timer and limit clamp
`timescale 1ns/1ps
`default_nettype none
module gain_step_channel (
   // Clock
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      ce,
   // Control
   input  wire logic                      controlled,
   input  wire level_ctrl_pkg::limits_type limits,
   input  wire level_ctrl_pkg::gain_type  static_gain,
   input  wire logic [31:0]               hold_base,
   input  wire logic [3:0]                hold_code,
   input  wire logic                      gate_hold,
   input  wire logic                      overload,
   // Rate ticks and detector
   input  wire logic                      above_target,
   input  wire logic                      attack_tick,
   input  wire logic                      fast_attack_tick,
   input  wire logic                      decay_tick,
   // Result
   output level_ctrl_pkg::gain_type       gain_q,
   output logic                           hold_active
);
   logic [39:0]              hold_cnt_q;
   logic [39:0]              hold_target;
   logic                     hold_done;
   level_ctrl_pkg::gain_type gain_d;
   level_ctrl_pkg::gain_type stepped;

   // ==========================================
   // Hold timer: restarts whenever the peak is above target
   assign hold_target = {8'h00, hold_base} << (hold_code - 4'd1);
   assign hold_done   = (hold_code == 4'h0) || (hold_cnt_q >= hold_target);
   assign hold_active = controlled && !above_target && !hold_done;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hold_cnt_q <= 40'h00_0000_0000;
      end else if (ce) begin
         if (!controlled || above_target) begin
            hold_cnt_q <= 40'h00_0000_0000;
         end else if (!hold_done) begin
            hold_cnt_q <= hold_cnt_q + 40'h00_0000_0001;
         end
      end
   end

   // ==========================================
   // Gain stepping, one half-dB per tick
   always_comb begin
      stepped = gain_q;
      if (overload) begin
         if (fast_attack_tick) stepped = gain_q - 8'sd1;
      end else if (above_target) begin
         if (attack_tick) stepped = gain_q - 8'sd1;
      end else if (hold_done && !gate_hold && decay_tick) begin
         stepped = gain_q + 8'sd1;
      end
      // Clamp after stepping so a limit change also pulls gain in
      if (stepped > limits.ceiling) begin
         gain_d = limits.ceiling;
      end else if (stepped < limits.floor) begin
         gain_d = limits.floor;
      end else begin
         gain_d = stepped;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gain_q <= 8'sh00;
      end else if (ce) begin
         gain_q <= controlled ? gain_d : static_gain;
      end
   end

endmodule : gain_step_channel
`default_nettype wire

// *** verilog/adc_level_control_limits.sv ***
// Gain limits, hold, overload, noise gate, input mux and soft reset
`timescale 1ns/1ps
`default_nettype none
module adc_level_control_limits #(
   parameter int unsigned HOLD_BASE_CYCLES = level_ctrl_pkg::HOLD_BASE_CYCLES
) (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic                     ce,
   // Control port write
   input  wire logic                     wr_en,
   input  wire logic [6:0]               wr_addr,
   input  wire logic [8:0]               wr_data,
   // Detector and rate inputs
   input  wire logic [1:0]               above_target,
   input  wire logic signed [23:0]       sample_left,
   input  wire logic signed [23:0]       sample_right,
   input  wire logic signed [7:0]        input_level_dbfs,
   input  wire logic                     attack_tick,
   input  wire logic                     fast_attack_tick,
   input  wire logic                     decay_tick,
   // User static gains
   input  wire level_ctrl_pkg::gain_type static_gain_left,
   input  wire level_ctrl_pkg::gain_type static_gain_right,
   // Gain results
   output level_ctrl_pkg::gain_type      gain_left_q,
   output level_ctrl_pkg::gain_type      gain_right_q,
   output logic [1:0]                    hold_active,
   output logic [1:0]                    overload_q,
   output logic                          gate_active_q,
   // Input mux
   output logic [3:0]                    input_pair_enable_q,
   output logic                          midrail_select_q
);
   // ==========================================
   // Register file
   logic [8:0] cfg_one_q;
   logic [8:0] cfg_two_q;
   logic [8:0] gate_cfg_q;
   logic [8:0] atten_cfg_q;
   logic [8:0] mux_cfg_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_one_q   <= level_ctrl_pkg::RST_CFG_ONE;
         cfg_two_q   <= level_ctrl_pkg::RST_CFG_TWO;
         gate_cfg_q  <= level_ctrl_pkg::RST_GATE;
         atten_cfg_q <= level_ctrl_pkg::RST_ATTEN;
         mux_cfg_q   <= level_ctrl_pkg::RST_MUX;
      end else if (ce && wr_en) begin
         // Addresses outside the map are ignored
         if (wr_addr == level_ctrl_pkg::ADDR_SOFT_RST) begin
            cfg_one_q   <= level_ctrl_pkg::RST_CFG_ONE;
            cfg_two_q   <= level_ctrl_pkg::RST_CFG_TWO;
            gate_cfg_q  <= level_ctrl_pkg::RST_GATE;
            atten_cfg_q <= level_ctrl_pkg::RST_ATTEN;
            mux_cfg_q   <= level_ctrl_pkg::RST_MUX;
         end
         if (wr_addr == level_ctrl_pkg::ADDR_CFG_ONE) begin
            cfg_one_q <= wr_data;
         end
         if (wr_addr == level_ctrl_pkg::ADDR_CFG_TWO) begin
            cfg_two_q <= wr_data;
         end
         if (wr_addr == level_ctrl_pkg::ADDR_GATE) begin
            gate_cfg_q <= wr_data;
         end
         if (wr_addr == level_ctrl_pkg::ADDR_ATTEN) begin
            atten_cfg_q <= wr_data;
         end
         if (wr_addr == level_ctrl_pkg::ADDR_MUX) begin
            mux_cfg_q <= wr_data;
         end
      end
   end

   // ==========================================
   // Field extraction
   level_ctrl_pkg::level_func_type level_function_select;
   logic       level_control_enable;
   logic [2:0] gain_ceiling;
   logic [3:0] gain_floor_limit;
   logic [3:0] rampup_hold_time;
   logic       quiet_gate_enable;
   logic [2:0] quiet_gate_threshold;
   logic [3:0] input_pair_select;
   logic       input_buffer_powerdown;

   assign level_function_select = level_ctrl_pkg::level_func_type'(
      cfg_one_q[level_ctrl_pkg::FUNC_SEL_LSB +: 2]);
   assign gain_ceiling = cfg_one_q[level_ctrl_pkg::CEIL_LSB +: 3];
   assign level_control_enable = cfg_two_q[level_ctrl_pkg::ENABLE_BIT];
   assign rampup_hold_time = cfg_two_q[level_ctrl_pkg::HOLD_LSB +: 4];
   assign quiet_gate_enable = gate_cfg_q[level_ctrl_pkg::GATE_EN_BIT];
   assign quiet_gate_threshold = gate_cfg_q[level_ctrl_pkg::GATE_TH_LSB +: 3];
   assign gain_floor_limit = atten_cfg_q[level_ctrl_pkg::FLOOR_LSB +: 4];
   assign input_pair_select = mux_cfg_q[level_ctrl_pkg::SELECT_LSB +: 4];
   assign input_buffer_powerdown = mux_cfg_q[level_ctrl_pkg::POWERDOWN_BIT];

   // ==========================================
   // Function decode
   logic       limiter_on;
   logic [1:0] alc_on;
   logic [1:0] controlled;

   always_comb begin
      limiter_on = 1'b0;
      alc_on     = 2'b00;
      unique case (level_function_select)
         level_ctrl_pkg::FUNC_LIMITER:    limiter_on = 1'b1;
         level_ctrl_pkg::FUNC_ALC_RIGHT:  alc_on = 2'b10;
         level_ctrl_pkg::FUNC_ALC_LEFT:   alc_on = 2'b01;
         level_ctrl_pkg::FUNC_ALC_STEREO: alc_on = 2'b11;
      endcase
      // Nothing runs with the circuit disabled
      if (!level_control_enable) begin
         limiter_on = 1'b0;
         alc_on     = 2'b00;
      end
   end

   // Index 0 is left, index 1 is right
   assign controlled = alc_on | {2{limiter_on}};

   // ==========================================
   // Limits
   level_ctrl_pkg::gain_type alc_ceiling;
   level_ctrl_pkg::gain_type alc_floor;
   logic [3:0]               atten_code;
   level_ctrl_pkg::limits_type limits_left;
   level_ctrl_pkg::limits_type limits_right;

   // Codes 001 and 000 both land on 0 dB
   assign alc_ceiling = (gain_ceiling <= 3'h1) ? 8'sh00 :
      $signed({2'b00, gain_ceiling - 3'h1, 3'b000});

   assign alc_floor =
      (gain_floor_limit < level_ctrl_pkg::ALC_FLOOR_KNEE) ?
      level_ctrl_pkg::ALC_FLOOR_HI_HDB :
      level_ctrl_pkg::ALC_FLOOR_B_HDB - $signed({1'b0,
      3'(gain_floor_limit - level_ctrl_pkg::ALC_FLOOR_KNEE),
      3'b000});

   assign atten_code =
      (gain_floor_limit < level_ctrl_pkg::ATTEN_MIN_CODE) ?
      level_ctrl_pkg::ATTEN_MIN_CODE :
      (gain_floor_limit > level_ctrl_pkg::ATTEN_MAX_CODE) ?
      level_ctrl_pkg::ATTEN_MAX_CODE : gain_floor_limit;

   // Limiter never lifts gain above static; ceiling field is unused there
   function automatic level_ctrl_pkg::limits_type channel_limits(
      input logic lim, input level_ctrl_pkg::gain_type st);
      level_ctrl_pkg::limits_type r;
      logic signed [8:0] lo;
      lo = {st[7], st} - $signed({4'h0, atten_code, 1'b0});
      if (lim) begin
         r.ceiling = st;
         r.floor   = (lo < 9'(level_ctrl_pkg::PGA_MIN_HDB)) ?
                     level_ctrl_pkg::PGA_MIN_HDB : lo[7:0];
      end else begin
         r.ceiling = alc_ceiling;
         r.floor   = alc_floor;
      end
      return r;
   endfunction : channel_limits

   assign limits_left  = channel_limits(limiter_on, static_gain_left);
   assign limits_right = channel_limits(limiter_on, static_gain_right);

   // ==========================================
   // Overload detector, armed by level control only
   logic [23:0] mag_left;
   logic [23:0] mag_right;

   assign mag_left  = sample_left[23] ? ~sample_left : sample_left;
   assign mag_right = sample_right[23] ? ~sample_right : sample_right;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         overload_q <= 2'b00;
      end else if (ce) begin
         overload_q[0] <= alc_on[0] &&
            (mag_left > level_ctrl_pkg::OVERLOAD_LEVEL);
         overload_q[1] <= alc_on[1] &&
            (mag_right > level_ctrl_pkg::OVERLOAD_LEVEL);
      end
   end

   // ==========================================
   // Noise gate
   level_ctrl_pkg::gain_type gate_threshold;

   assign gate_threshold = level_ctrl_pkg::GATE_TH_BASE +
      $signed(8'(quiet_gate_threshold * level_ctrl_pkg::GATE_TH_STEP));

   // Gated like the overload detector: only while level control runs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gate_active_q <= 1'b0;
      end else if (ce) begin
         gate_active_q <= quiet_gate_enable && (|alc_on) &&
            (input_level_dbfs < gate_threshold);
      end
   end

   // ==========================================
   // Channel stepping
   gain_step_channel u_left (
      .mclk             (mclk),
      .sys_rst          (sys_rst),
      .ce               (ce),
      .controlled       (controlled[0]),
      .limits           (limits_left),
      .static_gain      (static_gain_left),
      .hold_base        (32'(HOLD_BASE_CYCLES)),
      .hold_code        (rampup_hold_time),
      .gate_hold        (gate_active_q && alc_on[0]),
      .overload         (overload_q[0]),
      .above_target     (above_target[0]),
      .attack_tick      (attack_tick),
      .fast_attack_tick (fast_attack_tick),
      .decay_tick       (decay_tick),
      .gain_q           (gain_left_q),
      .hold_active      (hold_active[0])
   );

   gain_step_channel u_right (
      .mclk             (mclk),
      .sys_rst          (sys_rst),
      .ce               (ce),
      .controlled       (controlled[1]),
      .limits           (limits_right),
      .static_gain      (static_gain_right),
      .hold_base        (32'(HOLD_BASE_CYCLES)),
      .hold_code        (rampup_hold_time),
      .gate_hold        (gate_active_q && alc_on[1]),
      .overload         (overload_q[1]),
      .above_target     (above_target[1]),
      .attack_tick      (attack_tick),
      .fast_attack_tick (fast_attack_tick),
      .decay_tick       (decay_tick),
      .gain_q           (gain_right_q),
      .hold_active      (hold_active[1])
   );

   // ==========================================
   // Input mux
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         input_pair_enable_q <= level_ctrl_pkg::RST_MUX[3:0];
         midrail_select_q    <= 1'b0;
      end else if (ce) begin
         // Powered-down buffer leaves every pair on the midrail reference
         input_pair_enable_q <= input_buffer_powerdown ?
            4'h0 : input_pair_select;
         midrail_select_q    <= input_buffer_powerdown;
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_alc_limits;
      (ce && alc_on[0] && !limiter_on) |=>
         (gain_left_q <= $past(alc_ceiling)) &&
         (gain_left_q >= $past(alc_floor));
   endproperty
   a_alc_limits: assert property (p_alc_limits)
      else $error("Left gain outside level control limits");

   property p_limiter_ceiling;
      (ce && limiter_on) |=> (gain_right_q <= $past(static_gain_right));
   endproperty
   a_limiter_ceiling: assert property (p_limiter_ceiling)
      else $error("Limiter raised gain above static gain");

   property p_limiter_floor;
      (ce && limiter_on && gain_floor_limit == 4'hC &&
       static_gain_left == 8'sd4) |=> (gain_left_q >= -8'sd20);
   endproperty
   a_limiter_floor: assert property (p_limiter_floor)
      else $error("Limiter attenuated beyond twelve dB");

   property p_floor_code;
      (alc_on[0] && gain_floor_limit == 4'hF) |->
         (limits_left.floor == -8'sd42);
   endproperty
   a_floor_code: assert property (p_floor_code)
      else $error("Floor code 15 not at -21 dB");

   property p_overload_fast;
      (ce && overload_q[0] && fast_attack_tick &&
       gain_left_q > limits_left.floor + 8'sd1 && !wr_en) |=>
         (gain_left_q == $past(gain_left_q) - 8'sd1);
   endproperty
   a_overload_fast: assert property (p_overload_fast)
      else $error("Overload did not step gain down");

   property p_gate_freeze;
      (ce && gate_active_q && alc_on[0] && !overload_q[0] &&
       !above_target[0] && !wr_en &&
       gain_left_q >= limits_left.floor) |=>
         (gain_left_q <= $past(gain_left_q));
   endproperty
   a_gate_freeze: assert property (p_gate_freeze)
      else $error("Gain rose while noise gate active");

   property p_mux_pd;
      (ce && input_buffer_powerdown) |=>
         (midrail_select_q && input_pair_enable_q == 4'h0);
   endproperty
   a_mux_pd: assert property (p_mux_pd)
      else $error("Powerdown did not route to midrail");

   property p_mux_sel;
      (ce && !input_buffer_powerdown) |=>
         (input_pair_enable_q == $past(input_pair_select));
   endproperty
   a_mux_sel: assert property (p_mux_sel)
      else $error("Pair enables do not follow selection");

   property p_soft_reset;
      (ce && wr_en && wr_addr == level_ctrl_pkg::ADDR_SOFT_RST) |=>
         (cfg_one_q == level_ctrl_pkg::RST_CFG_ONE) &&
         (atten_cfg_q == level_ctrl_pkg::RST_ATTEN) &&
         (mux_cfg_q == level_ctrl_pkg::RST_MUX);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("Soft reset left a register off default");

   property p_disabled;
      (ce && !level_control_enable) |=>
         (gain_left_q == $past(static_gain_left)) && (overload_q == 2'b00);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("Gain control acted while disabled");

endmodule : adc_level_control_limits
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench for the level control limits block
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========================================
   // Stimulus and observed signals
   logic                     mclk = 1'b0;
   logic                     sys_rst = 1'b1;
   logic                     wr_en = 1'b0;
   logic [6:0]               wr_addr = 7'h00;
   logic [8:0]               wr_data = 9'h000;
   logic [1:0]               above_target = 2'b00;
   logic signed [23:0]       sample_left = 24'sh00_0000;
   logic signed [23:0]       sample_right = 24'sh00_0000;
   logic signed [7:0]        input_level_dbfs = 8'sh00;
   logic                     attack_tick = 1'b0;
   logic                     fast_attack_tick = 1'b0;
   logic                     decay_tick = 1'b0;
   level_ctrl_pkg::gain_type static_gain = 8'sh00;
   level_ctrl_pkg::gain_type gain_left_q;
   level_ctrl_pkg::gain_type gain_right_q;
   logic [1:0]               hold_active;
   logic [1:0]               overload_q;
   logic                     gate_active_q;
   logic [3:0]               input_pair_enable_q;
   logic                     midrail_select_q;
   int                       failures = 0;
   int                       check_count = 0;

   // Short hold base keeps the doubling hold times inside a quick run
   adc_level_control_limits #(.HOLD_BASE_CYCLES(4)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .above_target(above_target), .sample_left(sample_left),
      .sample_right(sample_right), .input_level_dbfs(input_level_dbfs),
      .attack_tick(attack_tick), .fast_attack_tick(fast_attack_tick),
      .decay_tick(decay_tick), .static_gain_left(static_gain),
      .static_gain_right(static_gain), .gain_left_q(gain_left_q),
      .gain_right_q(gain_right_q), .hold_active(hold_active), .overload_q(overload_q),
      .gate_active_q(gate_active_q), .input_pair_enable_q(input_pair_enable_q),
      .midrail_select_q(midrail_select_q));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   // ==========================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk_gain(input level_ctrl_pkg::gain_type g, input level_ctrl_pkg::gain_type e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: gain %0d expected %0d", $time, g, e);
      end
   endtask : chk_gain

   task automatic chk_bits(input logic [3:0] g, input logic [3:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: bits %b expected %b", $time, g, e);
      end
   endtask : chk_bits

   task automatic rst;
      sys_rst = 1'b1;
      tick(10);
      sys_rst = 1'b0;
   endtask : rst

   // Write lands at the next edge; its effect shows one edge later
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      tick(1);
      wr_en = 1'b0;
      tick(1);
   endtask : wr

   task automatic ramp(input logic up, input int n);
      decay_tick = up;
      attack_tick = !up;
      above_target = up ? 2'b00 : 2'b11;
      tick(n);
      decay_tick = 1'b0;
      attack_tick = 1'b0;
      tick(2);
   endtask : ramp

   // ==========================================
   // Scenarios
   task automatic test_defaults_and_mux;
      chk_bits(input_pair_enable_q, 4'h1);
      chk_bits({3'b000, midrail_select_q}, 4'h0);
      ramp(1'b0, 5);
      chk_gain(gain_left_q, 8'sh00);
      wr(7'h15, 9'h005);
      chk_bits(input_pair_enable_q, 4'h5);
      wr(7'h15, 9'h04F);
      chk_bits({midrail_select_q, input_pair_enable_q[2:0]}, 4'h8);
      wr(7'h17, 9'h1FF);
      chk_bits({midrail_select_q, input_pair_enable_q[2:0]}, 4'h1);
      $display("test defaults_and_mux done");
   endtask : test_defaults_and_mux

   task automatic test_alc_limits;
      wr(7'h11, 9'h100);
      for (int c = 7; c >= 0; c--) begin
         wr(7'h10, {2'b11, c[2:0], 4'hB});
         ramp(1'b1, 55);
         chk_gain(gain_left_q, 8'(c < 2 ? 0 : (c - 1) * 8));
         chk_gain(gain_right_q, 8'(c < 2 ? 0 : (c - 1) * 8));
      end
      for (int c = 0; c < 16; c++) begin
         wr(7'h14, {5'h0A, c[3:0]});
         ramp(1'b0, 45);
         chk_gain(gain_left_q, 8'(c <= 10 ? -2 : -10 - (c - 11) * 8));
      end
      wr(7'h14, 9'h0A6);
      tick(2);
      chk_gain(gain_left_q, -8'sd2);
      $display("test alc_limits done");
   endtask : test_alc_limits

   task automatic test_limiter;
      rst();
      static_gain = 8'sd4;
      wr(7'h10, 9'h00B);
      wr(7'h11, 9'h100);
      for (int c = 0; c <= 12; c++) begin
         wr(7'h14, {5'h0A, c[3:0]});
         ramp(1'b0, 30);
         chk_gain(gain_left_q, 8'(4 - 2 * (c < 3 ? 3 : c)));
      end
      ramp(1'b1, 40);
      chk_gain(gain_right_q, 8'sd4);
      static_gain = 8'sh00;
      $display("test limiter done");
   endtask : test_limiter

   task automatic test_overload;
      rst();
      wr(7'h10, 9'h17B);
      wr(7'h11, 9'h100);
      sample_left = 24'sh70_0001;
      sample_right = 24'sh7F_FFFF;
      tick(2);
      chk_bits({2'b00, overload_q}, 4'h1);
      fast_attack_tick = 1'b1;
      tick(1);
      fast_attack_tick = 1'b0;
      tick(1);
      chk_gain(gain_left_q, -8'sd1);
      sample_left = 24'sh70_0000;
      tick(2);
      chk_bits({2'b00, overload_q}, 4'h0);
      sample_left = 24'sh7F_FFFF;
      // Right-only level control arms only the right detector
      wr(7'h10, 9'h0FB);
      chk_bits({2'b00, overload_q}, 4'h2);
      wr(7'h17, 9'h000);
      tick(1);
      chk_bits({2'b00, overload_q}, 4'h0);
      // Loud samples left standing would mask later gain checks
      sample_left = 24'sh00_0000;
      sample_right = 24'sh00_0000;
      $display("test overload done");
   endtask : test_overload

   task automatic test_gate;
      rst();
      wr(7'h10, 9'h1FB);
      wr(7'h11, 9'h100);
      wr(7'h13, 9'h01D);
      input_level_dbfs = -8'sd37;
      tick(2);
      chk_bits({3'b000, gate_active_q}, 4'h1);
      input_level_dbfs = -8'sd36;
      tick(2);
      chk_bits({3'b000, gate_active_q}, 4'h0);
      wr(7'h13, 9'h001);
      input_level_dbfs = -8'sd79;
      tick(2);
      chk_bits({3'b000, gate_active_q}, 4'h1);
      ramp(1'b1, 10);
      chk_gain(gain_left_q, 8'sh00);
      wr(7'h13, 9'h000);
      chk_bits({3'b000, gate_active_q}, 4'h0);
      wr(7'h13, 9'h001);
      wr(7'h10, 9'h07B);
      tick(1);
      chk_bits({3'b000, gate_active_q}, 4'h0);
      input_level_dbfs = 8'sh00;
      $display("test gate done");
   endtask : test_gate

   task automatic test_hold;
      int n;
      rst();
      wr(7'h10, 9'h1FB);
      wr(7'h11, 9'h102);
      above_target = 2'b11;
      attack_tick = 1'b1;
      tick(1);
      attack_tick = 1'b0;
      chk_gain(gain_left_q, -8'sd1);
      above_target = 2'b00;
      decay_tick = 1'b1;
      tick(1);
      chk_bits({2'b00, hold_active}, 4'h3);
      n = 1;
      while (gain_left_q === -8'sd1 && n < 40) begin
         tick(1);
         n++;
      end
      decay_tick = 1'b0;
      if (n >= 40) begin
         failures++;
         $display("mismatch at %0t: gain never rose after hold", $time);
         wrap_up();
      end
      // Code 2 holds for base 4 doubled once, 8 edges; the step lands on the 9th
      chk_gain(8'(n), 8'sd9);
      chk_bits({2'b00, hold_active}, 4'h0);
      $display("test hold done");
   endtask : test_hold

   initial begin
      rst();
      test_defaults_and_mux();
      test_alc_limits();
      test_limiter();
      test_overload();
      test_gate();
      test_hold();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
